// ===== src/npa_pkg.sv
// Operation
// - Memories use 128-byte pages and share one 64-byte half-page buffer.
// - Page erase clears 128 bytes; each code or signature write programs only one 64-byte half, a fuse write the 19-byte row.
// - Code flash holds 32768 bytes in 256 pages, 0000H to 7FFFH.
// - User signature is 512 bytes, four pages, 0000H to 01FFH.
// - Read-only maker signature is 128 bytes at 0200H to 027FH.
// - External erase or write of user signature needs the programming fuse.
// - Chip erase clears user pages 0 and 1, page 2 by fuse, never 3.
// - Lock bits block external signature programming; reads always allowed.
// - Firmware may modify the user signature regardless of fuse and locks.
// - Calibration byte at 0180H sets oscillator trim at power-up.
// - Boot status 0000H, boot vector 0001H, security byte 0080H, with defaults.
// - Maker signature offset 0008H holds a copy of factory trim.
// - Maker offsets 00,01,02,30,31,60,61 hold identity bytes.
// - Nineteen fuses, one byte each, states FFH and 00H.
// - Fuses program like code bytes but chip erase leaves them.
// - Writing 00H clears a fuse; only row erase sets it again.
// - Bootloader has restricted fuse access; external programmer has full access.
package npa_pkg;
   // Register offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_ADDR = 8'h04;
   localparam logic [7:0] A_DATA = 8'h08;
   localparam logic [7:0] A_RDATA = 8'h0c;
   localparam logic [7:0] A_STAT = 8'h10;
   localparam logic [7:0] A_LOCK = 8'h14;
   localparam int STAT_REFUSED_BIT = 1;
   // Memory geometry
   localparam int PAGE_BYTES = 128;
   localparam int HALF_BYTES = 64;
   localparam int CODE_BYTES = 32768;
   localparam int USIG_BYTES = 512;
   localparam int FUSE_BYTES = 19;
   localparam logic [15:0] CODE_LAST = 16'h7fff;
   localparam logic [15:0] MAKER_BASE = 16'h0200;
   localparam logic [15:0] MAKER_LAST = 16'h027f;
   localparam logic [15:0] FUSE_LAST = 16'h0012;
   localparam logic [15:0] PAGE_LAST = 16'h007f;
   localparam logic [15:0] HALF_LAST = 16'h003f;
   localparam logic [15:0] USIG_CHIP_LAST = 16'h00ff;
   localparam logic [15:0] USIG_CHIP_LAST_FUSE = 16'h017f;
   localparam logic [4:0] USIG_FUSE_IDX = 5'h0a;
   // Parameter bytes of the user signature and their defaults
   localparam logic [8:0] BOOT_STATUS_ADDR = 9'h000;
   localparam logic [8:0] BOOT_VECTOR_ADDR = 9'h001;
   localparam logic [8:0] SECURITY_ADDR = 9'h080;
   localparam logic [8:0] TRIM_ADDR = 9'h180;
   localparam logic [7:0] BOOT_STATUS_DEF = 8'hff;
   localparam logic [7:0] BOOT_VECTOR_DEF = 8'hfc;
   localparam logic [7:0] SECURITY_DEF = 8'hff;
   // Maker array layout
   localparam logic [6:0] MK_TRIM_OFS = 7'h08;
   localparam logic [6:0] MK_ID_OFS [7] = '{7'h00, 7'h01, 7'h02, 7'h30, 7'h31, 7'h60, 7'h61};
   // Byte states
   localparam logic [7:0] ERASED = 8'hff;
   localparam logic [7:0] CLEARED = 8'h00;

   typedef enum logic [2:0] {
      CMD_NONE = 3'h0,
      CMD_PAGE_ERASE = 3'h1,
      CMD_PAGE_WRITE = 3'h2,
      CMD_CHIP_ERASE = 3'h3,
      CMD_FUSE_AUTO = 3'h4,
      CMD_BUF_CLEAR = 3'h5
   } npa_cmd_e;
   typedef enum logic [1:0] {PATH_EXT = 2'h0, PATH_FIRMWARE = 2'h1, PATH_BOOT = 2'h2} npa_path_e;
   typedef enum logic [1:0] {SP_CODE = 2'h0, SP_SIG = 2'h1, SP_FUSE = 2'h2} npa_space_e;
   typedef enum logic [1:0] {OP_ERASE = 2'h0, OP_PROG = 2'h1, OP_LOAD = 2'h2} npa_op_e;
   typedef enum logic [1:0] {ST_BOOT = 2'h0, ST_IDLE = 2'h1, ST_RUN = 2'h2} npa_state_e;

   typedef struct packed {
      npa_state_e state;
      logic [15:0] addr;
      npa_space_e space;
      npa_space_e rsp;
      npa_path_e path;
      npa_op_e op;
      logic chip;
      logic [15:0] base;
      logic [15:0] cnt;
      logic [15:0] last;
      logic busy;
      logic refused;
      logic lock;
      logic fuse_en;
      logic buf_clr;
      logic [31:0] rdata;
      logic [7:0] trim;
      logic [7:0] boot_status;
      logic [7:0] boot_vector;
      logic [7:0] security;
   } npa_state_s;
endpackage

// ===== src/npa_req_if.sv
`timescale 1ns/1ps
// Command request checked for permission
interface npa_req_if;
   npa_pkg::npa_cmd_e cmd;
   npa_pkg::npa_path_e path;
   npa_pkg::npa_space_e space;
   logic maker;
   logic fuse_en;
   logic lock;
   logic allow;
   modport gate (input cmd, path, space, maker, fuse_en, lock, output allow);
   modport user (output cmd, path, space, maker, fuse_en, lock, input allow);
endinterface

// ===== src/npa_gate.sv
`timescale 1ns/1ps
module npa_gate (
   // Request and verdict
   npa_req_if.gate req
);
   // Decide whether a command may start on the given path and space
   always_comb
   begin
      req.allow = 1'b0;
      unique case (req.cmd)
         npa_pkg::CMD_BUF_CLEAR:
            req.allow = 1'b1;
         npa_pkg::CMD_CHIP_ERASE:
            req.allow = (req.path == npa_pkg::PATH_EXT);
         npa_pkg::CMD_FUSE_AUTO: // Row erase only from the external programmer
            req.allow = (req.path == npa_pkg::PATH_EXT) && (req.space == npa_pkg::SP_FUSE);
         npa_pkg::CMD_PAGE_ERASE, npa_pkg::CMD_PAGE_WRITE:
         begin
            unique case (req.space)
               npa_pkg::SP_CODE:
                  req.allow = (req.path != npa_pkg::PATH_EXT) || !req.lock;
               npa_pkg::SP_SIG:
                  req.allow = !req.maker
                     && ((req.path != npa_pkg::PATH_EXT) || (req.fuse_en && !req.lock));
               npa_pkg::SP_FUSE: // Only clearing writes, never a plain erase
                  req.allow = (req.cmd == npa_pkg::CMD_PAGE_WRITE);
               default:
                  req.allow = 1'b0;
            endcase
         end
         default:
            req.allow = 1'b0;
      endcase
   end
endmodule

// ===== src/npa_top.sv
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module npa_top #(
   parameter logic [55:0] MAKER_ID = 56'h5a_a5_3c_c3_96_69_0f, // Arbitrary identity bytes
   parameter logic [7:0] FACTORY_TRIM = 8'h80
) (
   // Clock and reset
   input wire logic I_MCLK,
   input wire logic I_RST_N,
   // Register port
   input wire logic [7:0] I_ADDR,
   input wire logic [31:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [31:0] O_RDATA,
   // Status and power-up values
   output logic O_BUSY,
   output logic O_USIG_PROG_EN,
   output logic [7:0] O_RC_TRIM,
   output logic [7:0] O_BOOT_STATUS,
   output logic [7:0] O_BOOT_VECTOR,
   output logic [7:0] O_SECURITY
);
   npa_pkg::npa_state_s r;
   npa_pkg::npa_state_s nx;
   npa_req_if req ();
   logic [7:0] code_mem [npa_pkg::CODE_BYTES];
   logic [7:0] usig_mem [npa_pkg::USIG_BYTES];
   logic [7:0] fuse_mem [npa_pkg::FUSE_BYTES];
   logic [7:0] buf_mem [npa_pkg::HALF_BYTES];
   logic idle;
   logic run;
   logic buf_we;
   logic code_we;
   logic usig_we;
   logic fuse_we;
   logic [15:0] wa;
   logic [7:0] wd;
   logic [7:0] old;
   logic [7:0] rd_byte;
   logic [7:0] trim_src;

   // Maker array contents: identity bytes, trim copy, rest erased
   function automatic logic [7:0] maker_byte(input logic [6:0] ofs);
      logic [7:0] b;
      b = (ofs == npa_pkg::MK_TRIM_OFS) ? FACTORY_TRIM : npa_pkg::ERASED;
      for (int i = 0; i < 7; i++)
         if (ofs == npa_pkg::MK_ID_OFS[i])
            b = MAKER_ID[8 * (6 - i) +: 8];
      return b;
   endfunction

   // Byte seen at an address of a space; reads need no permission
   function automatic logic [7:0] byte_at(input npa_pkg::npa_space_e sp, input logic [15:0] a);
      logic [7:0] b;
      b = npa_pkg::ERASED;
      unique case (sp)
         npa_pkg::SP_CODE:
            if (a <= npa_pkg::CODE_LAST)
               b = code_mem[a[14:0]];
         npa_pkg::SP_SIG:
            if (a < npa_pkg::MAKER_BASE)
               b = usig_mem[a[8:0]];
            else if (a <= npa_pkg::MAKER_LAST)
               b = maker_byte(a[6:0]);
         npa_pkg::SP_FUSE:
            if (a <= npa_pkg::FUSE_LAST)
               b = fuse_mem[a[4:0]];
         default:
            b = npa_pkg::ERASED;
      endcase
      return b;
   endfunction

   // Value a chip erase leaves in the user signature
   function automatic logic [7:0] usig_default(input logic [8:0] a);
      logic [7:0] b;
      b = npa_pkg::ERASED;
      if (a == npa_pkg::BOOT_STATUS_ADDR)
         b = npa_pkg::BOOT_STATUS_DEF;
      if (a == npa_pkg::BOOT_VECTOR_ADDR)
         b = npa_pkg::BOOT_VECTOR_DEF;
      if (a == npa_pkg::SECURITY_ADDR)
         b = npa_pkg::SECURITY_DEF;
      return b;
   endfunction

   npa_gate u_gate (
      .req(req.gate)
   );

   // Sequencer write port and decoded strobes
   assign idle = (r.state == npa_pkg::ST_IDLE);
   assign run = (r.state == npa_pkg::ST_RUN);
   assign wa = r.base + r.cnt;
   assign old = byte_at(r.rsp, wa);
   assign rd_byte = byte_at(r.space, r.addr);
   assign trim_src = usig_mem[npa_pkg::TRIM_ADDR];
   assign buf_we = I_WR && idle && (I_ADDR == npa_pkg::A_DATA);
   assign code_we = run && (r.rsp == npa_pkg::SP_CODE);
   assign usig_we = run && (r.rsp == npa_pkg::SP_SIG) && (wa < npa_pkg::MAKER_BASE);
   assign fuse_we = run && (r.rsp == npa_pkg::SP_FUSE) && !r.chip;

   // Data written per operation; programming only clears bits
   always_comb
   begin
      unique case (r.op)
         npa_pkg::OP_ERASE:
            wd = (r.chip && r.rsp == npa_pkg::SP_SIG) ? usig_default(wa[8:0])
               : npa_pkg::ERASED;
         npa_pkg::OP_PROG:
            wd = old & buf_mem[r.cnt[5:0]];
         npa_pkg::OP_LOAD:
            wd = buf_mem[r.cnt[5:0]]; // No erase pass runs; the image replaces the row
         default:
            wd = npa_pkg::ERASED;
      endcase
   end

   // Permission request for a command write
   always_comb
   begin
      req.cmd = npa_pkg::npa_cmd_e'(I_WDATA[2:0]);
      req.path = npa_pkg::npa_path_e'(I_WDATA[5:4]);
      req.space = r.space;
      req.maker = (r.space == npa_pkg::SP_SIG) && (r.addr >= npa_pkg::MAKER_BASE);
      req.fuse_en = r.fuse_en;
      req.lock = r.lock;
   end

   // Next state of registers and sequencer
   always_comb
   begin
      nx = r;
      nx.rdata = '0;
      nx.buf_clr = 1'b0;
      nx.fuse_en = (fuse_mem[npa_pkg::USIG_FUSE_IDX] == npa_pkg::CLEARED);
      if (I_WR && I_ADDR == npa_pkg::A_STAT && I_WDATA[npa_pkg::STAT_REFUSED_BIT])
         nx.refused = 1'b0;
      if (I_WR && I_ADDR == npa_pkg::A_LOCK && I_WDATA[0])
         nx.lock = 1'b1;
      if (I_WR && !idle && (I_ADDR == npa_pkg::A_ADDR || I_ADDR == npa_pkg::A_DATA))
         nx.refused = 1'b1;
      if (I_WR && I_ADDR == npa_pkg::A_CTRL && (!idle || !req.allow))
         nx.refused = 1'b1;
      unique case (r.state)
         npa_pkg::ST_BOOT:
         begin
            nx.trim = trim_src;
            nx.boot_status = usig_mem[npa_pkg::BOOT_STATUS_ADDR];
            nx.boot_vector = usig_mem[npa_pkg::BOOT_VECTOR_ADDR];
            nx.security = usig_mem[npa_pkg::SECURITY_ADDR];
            nx.state = npa_pkg::ST_IDLE;
         end
         npa_pkg::ST_IDLE:
         begin
            if (I_WR && I_ADDR == npa_pkg::A_ADDR)
            begin
               nx.addr = I_WDATA[15:0];
               nx.space = npa_pkg::npa_space_e'(I_WDATA[17:16]);
            end
            if (buf_we)
               nx.addr = r.addr + 16'h0001;
            if (I_WR && I_ADDR == npa_pkg::A_CTRL && req.allow)
            begin
               nx.path = req.path;
               nx.rsp = r.space;
               nx.cnt = '0;
               nx.chip = 1'b0;
               nx.state = npa_pkg::ST_RUN;
               unique case (req.cmd)
                  npa_pkg::CMD_PAGE_ERASE:
                  begin
                     nx.base = {r.addr[15:7], 7'h00}; // Whole page
                     nx.last = npa_pkg::PAGE_LAST;
                     nx.op = npa_pkg::OP_ERASE;
                  end
                  npa_pkg::CMD_PAGE_WRITE:
                  begin
                     nx.base = (r.space == npa_pkg::SP_FUSE) ? '0 : {r.addr[15:6], 6'h00};
                     nx.last = (r.space == npa_pkg::SP_FUSE) ? npa_pkg::FUSE_LAST
                        : npa_pkg::HALF_LAST; // Half page only
                     nx.op = npa_pkg::OP_PROG;
                  end
                  npa_pkg::CMD_CHIP_ERASE:
                  begin
                     nx.rsp = npa_pkg::SP_CODE;
                     nx.base = '0;
                     nx.last = npa_pkg::CODE_LAST;
                     nx.op = npa_pkg::OP_ERASE;
                     nx.chip = 1'b1;
                  end
                  npa_pkg::CMD_FUSE_AUTO:
                  begin
                     nx.base = '0;
                     nx.last = npa_pkg::FUSE_LAST;
                     nx.op = npa_pkg::OP_LOAD;
                  end
                  default:
                  begin
                     nx.buf_clr = 1'b1;
                     nx.state = npa_pkg::ST_IDLE;
                  end
               endcase
            end
         end
         npa_pkg::ST_RUN:
         begin
            nx.cnt = r.cnt + 16'h0001;
            if (r.cnt == r.last)
            begin
               if (r.chip && r.rsp == npa_pkg::SP_CODE)
               begin
                  nx.rsp = npa_pkg::SP_SIG;
                  nx.cnt = '0;
                  nx.last = r.fuse_en ? npa_pkg::USIG_CHIP_LAST_FUSE
                     : npa_pkg::USIG_CHIP_LAST;
               end
               else
               begin
                  nx.state = npa_pkg::ST_IDLE;
                  nx.buf_clr = (r.op != npa_pkg::OP_ERASE);
               end
            end
         end
         default:
            nx.state = npa_pkg::ST_IDLE;
      endcase
      nx.busy = (nx.state != npa_pkg::ST_IDLE);
      if (I_RD)
      begin
         case (I_ADDR)
            npa_pkg::A_ADDR:
               nx.rdata = {14'h0000, r.space, r.addr};
            npa_pkg::A_RDATA:
               nx.rdata = {24'h000000, rd_byte};
            npa_pkg::A_STAT:
               nx.rdata = {28'h0000000, r.fuse_en, r.lock, r.refused, r.busy};
            npa_pkg::A_LOCK:
               nx.rdata = {31'h00000000, r.lock};
            default:
               nx.rdata = '0;
         endcase
      end
   end

   // State register
   always_ff @(posedge I_MCLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         r <= '0;
         r.state <= npa_pkg::ST_BOOT;
         r.busy <= 1'b1;
      end
      else
         r <= nx;
   end

   // Nonvolatile arrays keep contents across reset
   always_ff @(posedge I_MCLK)
   begin
      if (code_we)
         code_mem[wa[14:0]] <= wd;
      if (usig_we)
         usig_mem[wa[8:0]] <= wd;
      if (fuse_we)
         fuse_mem[wa[4:0]] <= wd;
   end

   // Shared half-page buffer, erased at reset and after each program
   always_ff @(posedge I_MCLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
         for (int i = 0; i < npa_pkg::HALF_BYTES; i++)
            buf_mem[i] <= npa_pkg::ERASED;
      else if (r.buf_clr)
         for (int i = 0; i < npa_pkg::HALF_BYTES; i++)
            buf_mem[i] <= npa_pkg::ERASED;
      else if (buf_we)
         buf_mem[r.addr[5:0]] <= I_WDATA[7:0];
   end

   // Outputs straight from the state register
   assign O_RDATA = r.rdata;
   assign O_BUSY = r.busy;
   assign O_USIG_PROG_EN = r.fuse_en;
   assign O_RC_TRIM = r.trim;
   assign O_BOOT_STATUS = r.boot_status;
   assign O_BOOT_VECTOR = r.boot_vector;
   assign O_SECURITY = r.security;

   // Checks on the write paths and the register port
   maker_ro_a:
      assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
         I_WR && idle && I_ADDR == npa_pkg::A_CTRL && (I_WDATA[2:0] == 3'h1
         || I_WDATA[2:0] == 3'h2) && req.maker |=> r.refused && r.state == npa_pkg::ST_IDLE)
      else $error("maker array command was accepted");
   usig_gate_a:
      assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
         usig_we && !r.chip && r.path == npa_pkg::PATH_EXT |-> r.fuse_en && !r.lock)
      else $error("external signature write without fuse");
   chip_page3_a:
      assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
         usig_we && r.chip |-> wa[8:7] != 2'h3 && (wa[8:7] != 2'h2 || r.fuse_en))
      else $error("chip erase touched a protected page");
   fuse_chip_a:
      assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
         r.chip && run |-> r.rsp != npa_pkg::SP_FUSE)
      else $error("chip erase wrote the fuse row");
   fuse_clear_a:
      assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
         fuse_we && r.op == npa_pkg::OP_PROG |-> (wd & ~old) == 8'h00)
      else $error("plain fuse write set a bit");
   half_page_a:
      assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
         $rose(code_we) && r.op == npa_pkg::OP_PROG
         |-> ##63 (code_we && r.cnt == 16'h003f) ##1 !code_we)
      else $error("page write did not cover one half page");
   read_data_a:
      assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
         I_RD && I_ADDR == npa_pkg::A_RDATA |=> O_RDATA == {24'h000000, $past(rd_byte)})
      else $error("read data wrong or late");
   trim_boot_a:
      assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
         I_RST_N && r.state == npa_pkg::ST_BOOT |=> O_RC_TRIM === $past(trim_src) && !O_BUSY)
      else $error("trim not loaded at power-up");
endmodule

// ===== sim/npa_prog.sv
`timescale 1ns/1ps
module npa_prog (
   // Clock
   input wire logic i_clk,
   // Register port toward the device
   output logic [7:0] o_addr,
   output logic [31:0] o_wdata,
   output logic o_wr,
   output logic o_rd,
   input wire logic [31:0] i_rdata
);
   logic [7:0] img [npa_pkg::FUSE_BYTES];
   logic [31:0] d;

   // Bus idle at time zero
   initial
   begin
      o_addr = 8'h00;
      o_wdata = 32'h0;
      o_wr = 1'b0;
      o_rd = 1'b0;
   end

   // One write cycle; lines scrambled once released
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge i_clk);
      o_addr <= a;
      o_wdata <= v;
      o_wr <= 1'b1;
      @(posedge i_clk);
      o_wr <= 1'b0;
      o_addr <= ~a;
      o_wdata <= ~v;
   endtask

   // One read cycle; data taken in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge i_clk);
      o_addr <= a;
      o_rd <= 1'b1;
      @(posedge i_clk);
      o_rd <= 1'b0;
      o_addr <= ~a;
      @(negedge i_clk);
      v = i_rdata;
   endtask

   // Loads the whole fuse image and writes it with auto-erase
   task automatic fuse_write(input logic [1:0] path);
      wr(npa_pkg::A_ADDR, 32'h0002_0000);
      for (int i = 0; i < npa_pkg::FUSE_BYTES; i++)
         wr(npa_pkg::A_DATA, {24'h0, img[i]});
      wr(npa_pkg::A_CTRL, {26'h0, path, 1'b0, npa_pkg::CMD_FUSE_AUTO});
   endtask

   // Reads every fuse, edits one, rewrites the row
   task automatic fuse_update(input int idx, input logic [7:0] v);
      for (int i = 0; i < npa_pkg::FUSE_BYTES; i++)
      begin
         wr(npa_pkg::A_ADDR, 32'h0002_0000 | i);
         rd(npa_pkg::A_RDATA, d);
         img[i] = d[7:0];
      end
      img[idx] = v;
      fuse_write(npa_pkg::PATH_EXT);
   endtask
endmodule

// ===== sim/npa_top_tb.sv
`timescale 1ns/1ps
module npa_top_tb;
   localparam logic [55:0] ID = 56'h1b_2c_3d_4e_5f_60_71; // Arbitrary identity bytes
   localparam logic [7:0] FTRIM = 8'h4b;
   logic clk, rst_n, wr, rd, usig_en, busy, rd_q;
   logic [7:0] addr, trim, bstat, bvec, sec, v, t;
   logic [31:0] wdata, rdata, junk;
   logic [63:0] ent;
   logic [63:0] exp_q [$];
   int n_fail, checks;

   npa_top #(.MAKER_ID(ID), .FACTORY_TRIM(FTRIM)) dut (.I_MCLK(clk), .I_RST_N(rst_n),
      .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_BUSY(busy),
      .O_USIG_PROG_EN(usig_en), .O_RC_TRIM(trim), .O_BOOT_STATUS(bstat),
      .O_BOOT_VECTOR(bvec), .O_SECURITY(sec));
   npa_prog prog (.i_clk(clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd),
      .i_rdata(rdata));

   // Clock of 4 ns
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Compares each read answer with the oldest note
   always @(posedge clk) rd_q <= rd;
   always @(negedge clk)
   begin
      if (rd_q === 1'b1 && exp_q.size() > 0)
      begin
         ent = exp_q.pop_front();
         checks++;
         if ((rdata & ent[63:32]) !== (ent[31:0] & ent[63:32]))
         begin
            n_fail++;
            $display("BAD t=%0t got %h exp %h", $time, rdata, ent[31:0]);
         end
      end
   end

   task automatic conclude();
      $display("Counts: %0d checks, %0d mismatches", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Bounded wait for the device to go idle
   task automatic idle();
      int i;
      i = 0;
      @(negedge clk);
      while (busy !== 1'b0 && i < 40000)
      begin
         @(negedge clk);
         i++;
      end
      if (i == 40000)
      begin
         n_fail++;
         $display("BAD t=%0t busy got %h exp %h", $time, busy, 1'b0);
         conclude();
      end
   endtask

   task automatic pin(input logic [7:0] g, input logic [7:0] e);
      checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   // Bus helpers
   task automatic chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      exp_q.push_back({m, e});
      prog.rd(a, junk);
   endtask
   task automatic rb(input logic [1:0] sp, input logic [15:0] a, input logic [7:0] e);
      prog.wr(npa_pkg::A_ADDR, {14'h0, sp, a});
      chk(npa_pkg::A_RDATA, {24'h0, e}, 32'hff);
   endtask
   task automatic cmd(input logic [1:0] sp, input logic [15:0] a, input logic [1:0] p,
      input logic [2:0] c);
      prog.wr(npa_pkg::A_ADDR, {14'h0, sp, a});
      prog.wr(npa_pkg::A_CTRL, {26'h0, p, 1'b0, c});
      idle();
   endtask
   task automatic pw(input logic [1:0] sp, input logic [15:0] a, input logic [1:0] p,
      input logic [7:0] e);
      prog.wr(npa_pkg::A_ADDR, {14'h0, sp, a});
      prog.wr(npa_pkg::A_DATA, {24'h0, e});
      cmd(sp, a, p, npa_pkg::CMD_PAGE_WRITE);
   endtask
   task automatic pe(input logic [15:0] a, input logic [1:0] p);
      cmd(npa_pkg::SP_SIG, a, p, npa_pkg::CMD_PAGE_ERASE);
   endtask
   task automatic misc(input logic [2:0] c);
      cmd(npa_pkg::SP_CODE, 16'h0, npa_pkg::PATH_EXT, c);
   endtask
   task automatic refd(input logic e);
      chk(npa_pkg::A_STAT, {30'h0, e, 1'b0}, 32'h2);
      prog.wr(npa_pkg::A_STAT, 32'h2);
   endtask
   task automatic reset_dut();
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      idle();
   endtask

   // Main sequence
   initial
   begin
      rst_n = 1'b0;
      n_fail = 0;
      checks = 0;
      v = 8'($urandom(32'he976)) & 8'h7f;
      t = 8'($urandom()) & 8'h7f;
      reset_dut();
      for (int i = 0; i < npa_pkg::FUSE_BYTES; i++)
         prog.img[i] = 8'hff;
      prog.img[npa_pkg::USIG_FUSE_IDX] = 8'h00;
      prog.fuse_write(npa_pkg::PATH_EXT);
      idle();
      rb(npa_pkg::SP_FUSE, 16'h000a, 8'h00);
      rb(npa_pkg::SP_FUSE, 16'h0012, 8'hff);
      pin({7'h0, usig_en}, 8'h01);
      prog.fuse_write(npa_pkg::PATH_BOOT);
      idle();
      refd(1'b1);
      misc(npa_pkg::CMD_BUF_CLEAR);
      $display("Test fuse_row done");
      for (int p = 0; p < 4; p++)
      begin
         pe(16'(p*128), npa_pkg::PATH_FIRMWARE);
         rb(npa_pkg::SP_SIG, 16'(p*128+127), 8'hff);
         pw(npa_pkg::SP_SIG, 16'(p*128+16), npa_pkg::PATH_FIRMWARE, v);
         rb(npa_pkg::SP_SIG, 16'(p*128+16), v);
         rb(npa_pkg::SP_SIG, 16'(p*128+80), 8'hff);
      end
      misc(npa_pkg::CMD_CHIP_ERASE);
      rb(npa_pkg::SP_CODE, 16'h7fff, 8'hff);
      rb(npa_pkg::SP_SIG, 16'h0090, 8'hff);
      rb(npa_pkg::SP_SIG, 16'h0110, 8'hff);
      rb(npa_pkg::SP_SIG, 16'h0190, v);
      rb(npa_pkg::SP_SIG, 16'h0001, 8'hfc);
      rb(npa_pkg::SP_SIG, 16'h0080, 8'hff);
      rb(npa_pkg::SP_FUSE, 16'h000a, 8'h00);
      pw(npa_pkg::SP_CODE, 16'h0050, npa_pkg::PATH_EXT, t);
      rb(npa_pkg::SP_CODE, 16'h0050, t);
      rb(npa_pkg::SP_CODE, 16'h0010, 8'hff);
      $display("Test chip_erase done");
      pw(npa_pkg::SP_FUSE, 16'h0003, npa_pkg::PATH_FIRMWARE, 8'h00);
      rb(npa_pkg::SP_FUSE, 16'h0003, 8'h00);
      pw(npa_pkg::SP_FUSE, 16'h0003, npa_pkg::PATH_EXT, 8'hff);
      rb(npa_pkg::SP_FUSE, 16'h0003, 8'h00);
      prog.fuse_update(3, 8'hff);
      idle();
      rb(npa_pkg::SP_FUSE, 16'h0003, 8'hff);
      prog.fuse_update(10, 8'hff);
      idle();
      pin({7'h0, usig_en}, 8'h00);
      $display("Test fuse_clear done");
      pe(16'h0180, npa_pkg::PATH_EXT);
      refd(1'b1);
      pw(npa_pkg::SP_SIG, 16'h0190, npa_pkg::PATH_EXT, 8'h00);
      refd(1'b1);
      rb(npa_pkg::SP_SIG, 16'h0190, v);
      misc(npa_pkg::CMD_BUF_CLEAR);
      pe(16'h0100, npa_pkg::PATH_FIRMWARE);
      pw(npa_pkg::SP_SIG, 16'h0110, npa_pkg::PATH_FIRMWARE, v);
      misc(npa_pkg::CMD_CHIP_ERASE);
      rb(npa_pkg::SP_SIG, 16'h0110, v);
      rb(npa_pkg::SP_SIG, 16'h0010, 8'hff);
      $display("Test fuse_gating done");
      for (int i = 0; i < 7; i++)
         rb(npa_pkg::SP_SIG, 16'h0200 | 16'(npa_pkg::MK_ID_OFS[i]), ID[55-8*i -: 8]);
      rb(npa_pkg::SP_SIG, 16'h0208, FTRIM);
      for (int p = 0; p < 3; p++)
      begin
         pe(16'h0200, 2'(p));
         refd(1'b1);
      end
      rb(npa_pkg::SP_SIG, 16'h0208, FTRIM);
      chk(8'h18, 32'h0, 32'hffffffff);
      $display("Test maker done");
      prog.fuse_update(10, 8'h00);
      idle();
      pw(npa_pkg::SP_SIG, 16'h0120, npa_pkg::PATH_EXT, t);
      rb(npa_pkg::SP_SIG, 16'h0120, t);
      prog.wr(npa_pkg::A_LOCK, 32'h1);
      pw(npa_pkg::SP_SIG, 16'h0190, npa_pkg::PATH_EXT, 8'h00);
      refd(1'b1);
      rb(npa_pkg::SP_SIG, 16'h0190, v);
      misc(npa_pkg::CMD_BUF_CLEAR);
      pe(16'h0180, npa_pkg::PATH_FIRMWARE);
      pw(npa_pkg::SP_SIG, 16'h0180, npa_pkg::PATH_FIRMWARE, t);
      refd(1'b0);
      rb(npa_pkg::SP_SIG, 16'h0180, t);
      reset_dut();
      pin(trim, t);
      pin(bstat, 8'hff);
      pin(bvec, 8'hfc);
      pin(sec, 8'hff);
      $display("Test lock_powerup done");
      conclude();
   end
endmodule
